// >>> core/timer_edge_osc_input_regs.sv
`timescale 1ns/10ps
module timer_edge_osc_input_regs
  import timer_edge_osc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // cpu i/o access
  input  wire logic [7:0] ioAddr,
  input  wire logic       ioWrEn,
  input  wire logic       ioRdEn,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  // multiplier
  input  wire logic       mulStart,
  input  wire logic [7:0] mulOperand,
  input  wire logic [7:0] mulFactor,
  // asynchronous clock and pin levels
  input  wire logic       fastRcClk,
  input  wire logic       crystalClk,
  input  wire logic       slowRcClk,
  input  wire logic [7:0] portaPins,
  // timer request flag
  input  wire logic       timerReqClear,
  output logic            timerReqFlag,
  output logic      [15:0] timerCount,
  // pin events and power controls
  output logic            pinIrqFirst,
  output logic            pinIrqSecond,
  output logic            wakeEvent,
  output logic      [7:0] portaInputEnable,
  output logic            crystalEnable,
  output logic      [1:0] crystalDrive,
  output logic            bandgapPowerDown
);

  function automatic logic [5:0] divMask(input logic [1:0] code);
    divMask = 6'h00;
    case (code)
      2'h0:    divMask = 6'h00;
      2'h1:    divMask = 6'h03;
      2'h2:    divMask = 6'h0F;
      default: divMask = 6'h3F;
    endcase
  endfunction : divMask

  function automatic logic edgeHit(input logic [1:0] code, input logic prev, input logic cur);
    edgeHit = 1'b0;
    case (code)
      EDGE_BOTH: edgeHit = prev ^ cur;
      EDGE_RISE: edgeHit = !prev && cur;
      EDGE_FALL: edgeHit = prev && !cur;
      default:   edgeHit = 1'b0;
    endcase
  endfunction : edgeHit

  logic [7:0]  timerMode_q, timerMode_d;
  logic [7:0]  product_q, product_d;
  logic        crystalEn_q, crystalEn_d;
  logic [1:0]  drive_q, drive_d;
  logic        bandgapPd_q, bandgapPd_d;
  logic [4:0]  edgeSel_q, edgeSel_d;
  logic [7:0]  inEn_q, inEn_d;
  logic [7:0]  rdData_q, rdData_d;
  logic [15:0] count_q, count_d;
  logic [5:0]  preCnt_q, preCnt_d;
  logic        selPrev_q, selPrev_d;
  logic        reqFlag_q, reqFlag_d;
  logic        irqFirst_q, irqFirst_d;
  logic        irqSecond_q, irqSecond_d;
  logic        wake_q, wake_d;
  // synchronisers: stage one feeds stage two only
  logic [10:0] syncA_q, syncB_q, syncPrev_q;

  logic [2:0]  srcSel;
  logic        srcTick, divTick, selCur, timerEvt;
  logic [7:0]  pinCur, pinPrev;
  logic [15:0] fullProduct;

  always_comb begin
    srcSel  = timerMode_q[TM_SRC_MSB:TM_SRC_LSB];
    pinCur  = syncB_q[7:0];
    pinPrev = syncPrev_q[7:0];
    srcTick = 1'b0;
    case (srcSel)
      SRC_SYSTEM:    srcTick = 1'b1;
      SRC_PIN_FIRST: srcTick = pinPrev[PIN_FIRST_EXT] && !pinCur[PIN_FIRST_EXT];
      SRC_FAST_RC:   srcTick = !syncPrev_q[8] && syncB_q[8];
      SRC_CRYSTAL:   srcTick = crystalEn_q && !syncPrev_q[9] && syncB_q[9];
      SRC_SLOW_RC:   srcTick = !syncPrev_q[10] && syncB_q[10];
      SRC_PIN_SEC:   srcTick = pinPrev[PIN_SECOND_EXT] && !pinCur[PIN_SECOND_EXT];
      default:       srcTick = 1'b0;
    endcase
    // pre-divider passes one tick in 1, 4, 16 or 64
    divTick = srcTick &&
              ((preCnt_q & divMask(timerMode_q[TM_DIV_MSB:TM_DIV_LSB])) ==
               divMask(timerMode_q[TM_DIV_MSB:TM_DIV_LSB]));
    preCnt_d = srcTick ? preCnt_q + 6'h01 : preCnt_q;
    if (divTick) begin
      preCnt_d = 6'h00;
    end
    count_d = divTick ? count_q + 16'h0001 : count_q;
    selCur  = count_q[TIMER_BIT_BASE + 32'(timerMode_q[TM_BIT_MSB:TM_BIT_LSB])];
    selPrev_d = selCur;
    // sampled previous and present levels: one event per selected edge, rising or falling
    timerEvt = edgeSel_q[ES_TIMER_FALL] ? (selPrev_q && !selCur)
                                        : (!selPrev_q && selCur);
    // set wins over a clear in the same cycle
    reqFlag_d = timerEvt || (reqFlag_q && !timerReqClear);
    irqFirst_d = inEn_q[PIN_FIRST_EXT] &&
                 edgeHit(edgeSel_q[ES_FIRST_MSB:ES_FIRST_LSB],
                         pinPrev[PIN_FIRST_EXT], pinCur[PIN_FIRST_EXT]);
    irqSecond_d = inEn_q[PIN_SECOND_EXT] &&
                  edgeHit(edgeSel_q[ES_SECOND_MSB:ES_SECOND_LSB],
                          pinPrev[PIN_SECOND_EXT], pinCur[PIN_SECOND_EXT]);
    wake_d = |((pinPrev ^ pinCur) & inEn_q);
    fullProduct = 16'(mulOperand) * 16'(mulFactor);
    product_d = mulStart ? fullProduct[15:8] : product_q;
    timerMode_d = timerMode_q;
    crystalEn_d = crystalEn_q;
    drive_d     = drive_q;
    bandgapPd_d = bandgapPd_q;
    edgeSel_d   = edgeSel_q;
    inEn_d      = inEn_q;
    if (ioWrEn) begin
      case (ioAddr)
        ADDR_TIMER_MODE: timerMode_d = ioWrData;
        ADDR_CRYSTAL_SET: begin
          crystalEn_d = ioWrData[CS_ENABLE];
          drive_d     = ioWrData[CS_DRIVE_MSB:CS_DRIVE_LSB];
          bandgapPd_d = ioWrData[CS_BANDGAP_PD];
        end
        ADDR_EDGE_SELECT: edgeSel_d = ioWrData[ES_TIMER_FALL:0];
        // reserved bits 2 and 1 are not stored
        ADDR_PORTA_IN_EN: inEn_d = ioWrData & PORTA_IN_EN_MASK;
        default: ; // product high byte and others ignore writes
      endcase
    end
    // write-only registers read as zero
    rdData_d = rdData_q;
    if (ioRdEn) begin
      case (ioAddr)
        ADDR_TIMER_MODE:   rdData_d = timerMode_q;
        ADDR_PRODUCT_HIGH: rdData_d = product_q;
        default:           rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    syncA_q    <= {slowRcClk, crystalClk, fastRcClk, portaPins};
    syncB_q    <= syncA_q;
    syncPrev_q <= syncB_q;
    if (srst) begin
      timerMode_q <= TIMER_MODE_RESET;
      product_q   <= 8'h00;
      crystalEn_q <= 1'b0;
      drive_q     <= 2'h0;
      bandgapPd_q <= 1'b0;
      edgeSel_q   <= 5'h00;
      inEn_q      <= PORTA_IN_EN_RESET;
      rdData_q    <= 8'h00;
      count_q     <= 16'h0000;
      preCnt_q    <= 6'h00;
      selPrev_q   <= 1'b0;
      reqFlag_q   <= 1'b0;
      irqFirst_q  <= 1'b0;
      irqSecond_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      timerMode_q <= timerMode_d;
      product_q   <= product_d;
      crystalEn_q <= crystalEn_d;
      drive_q     <= drive_d;
      bandgapPd_q <= bandgapPd_d;
      edgeSel_q   <= edgeSel_d;
      inEn_q      <= inEn_d;
      rdData_q    <= rdData_d;
      count_q     <= count_d;
      preCnt_q    <= preCnt_d;
      selPrev_q   <= selPrev_d;
      reqFlag_q   <= reqFlag_d;
      irqFirst_q  <= irqFirst_d;
      irqSecond_q <= irqSecond_d;
      wake_q      <= wake_d;
    end
  end

  assign ioRdData         = rdData_q;
  assign timerReqFlag     = reqFlag_q;
  assign timerCount       = count_q;
  assign pinIrqFirst      = irqFirst_q;
  assign pinIrqSecond     = irqSecond_q;
  assign wakeEvent        = wake_q;
  assign portaInputEnable = inEn_q;
  assign crystalEnable    = crystalEn_q;
  assign crystalDrive     = drive_q;
  assign bandgapPowerDown = bandgapPd_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_writeTo(logic [7:0] a);
    ioWrEn && ioAddr == a;
  endsequence

  a_product_ro: assert property (s_writeTo(ADDR_PRODUCT_HIGH) and !mulStart |=>
    $stable(product_q) ##1 1'b1) else $error("product byte changed by a write");
  a_product_calc: assert property (mulStart |=>
    product_q == 8'(($past(16'(mulOperand)) * $past(16'(mulFactor))) >> 8))
    else $error("product high byte wrong");
  a_src_stopped: assert property ((srcSel == SRC_STOP || srcSel == SRC_RESERVED) |->
    !srcTick) else $error("timer ticks while stopped");
  a_div_mask: assert property (divTick |-> ((preCnt_q &
    divMask(timerMode_q[TM_DIV_MSB:TM_DIV_LSB])) ==
    divMask(timerMode_q[TM_DIV_MSB:TM_DIV_LSB]))) else $error("pre-divider early");
  a_count_step: assert property (divTick |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step");
  a_timer_edge: assert property (timerEvt |-> selPrev_q != selCur &&
    selCur == !edgeSel_q[ES_TIMER_FALL]) else $error("timer event on wrong edge");
  a_req_sticky: assert property (timerEvt |=> reqFlag_q ##1 (reqFlag_q || $past(timerReqClear)))
    else $error("request flag not held");
  a_pin_gate: assert property (!inEn_q[PIN_FIRST_EXT] |=> !irqFirst_q)
    else $error("disabled pin raised request");
  a_edge_reserved: assert property
    (edgeSel_q[ES_SECOND_MSB:ES_SECOND_LSB] == EDGE_RESERVED |=> !irqSecond_q)
    else $error("reserved edge code raised request");
  a_wake_gate: assert property (wake_q |-> $past(|((pinPrev ^ pinCur) & inEn_q)))
    else $error("wake from disabled pin");
  a_osc_write: assert property (s_writeTo(ADDR_CRYSTAL_SET) |=>
    crystalEn_q == $past(ioWrData[CS_ENABLE]) && bandgapPd_q == $past(ioWrData[CS_BANDGAP_PD]))
    else $error("oscillator settings not stored");
  a_drive_write: assert property (s_writeTo(ADDR_CRYSTAL_SET) |=>
    drive_q == $past(ioWrData[CS_DRIVE_MSB:CS_DRIVE_LSB])) else $error("drive not stored");

endmodule : timer_edge_osc_input_regs

// >>> shared/timer_edge_osc_pkg.sv
package timer_edge_osc_pkg;
  // i/o addresses
  localparam logic [7:0] ADDR_TIMER_MODE    = 8'h06;
  localparam logic [7:0] ADDR_PRODUCT_HIGH  = 8'h09;
  localparam logic [7:0] ADDR_CRYSTAL_SET   = 8'h0A;
  localparam logic [7:0] ADDR_EDGE_SELECT   = 8'h0C;
  localparam logic [7:0] ADDR_PORTA_IN_EN   = 8'h0D;
  // timer_mode fields
  localparam int TM_SRC_MSB  = 7;
  localparam int TM_SRC_LSB  = 5;
  localparam int TM_DIV_MSB  = 4;
  localparam int TM_DIV_LSB  = 3;
  localparam int TM_BIT_MSB  = 2;
  localparam int TM_BIT_LSB  = 0;
  localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
  // clock source codes
  localparam logic [2:0] SRC_STOP      = 3'h0;
  localparam logic [2:0] SRC_SYSTEM    = 3'h1;
  localparam logic [2:0] SRC_RESERVED  = 3'h2;
  localparam logic [2:0] SRC_PIN_FIRST = 3'h3;
  localparam logic [2:0] SRC_FAST_RC   = 3'h4;
  localparam logic [2:0] SRC_CRYSTAL   = 3'h5;
  localparam logic [2:0] SRC_SLOW_RC   = 3'h6;
  localparam logic [2:0] SRC_PIN_SEC   = 3'h7;
  // lowest counter bit that may raise the timer event
  localparam int TIMER_BIT_BASE = 8;
  // crystal_settings fields
  localparam int CS_ENABLE     = 7;
  localparam int CS_DRIVE_MSB  = 6;
  localparam int CS_DRIVE_LSB  = 5;
  localparam int CS_BANDGAP_PD = 0;
  // edge_select fields
  localparam int ES_TIMER_FALL  = 4;
  localparam int ES_FIRST_MSB   = 3;
  localparam int ES_FIRST_LSB   = 2;
  localparam int ES_SECOND_MSB  = 1;
  localparam int ES_SECOND_LSB  = 0;
  localparam logic [1:0] EDGE_BOTH     = 2'h0;
  localparam logic [1:0] EDGE_RISE     = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_RESERVED = 2'h3;
  // port a input enable
  localparam int PIN_FIRST_EXT  = 4;
  localparam int PIN_SECOND_EXT = 0;
  localparam logic [7:0] PORTA_IN_EN_RESET = 8'hF9;
  localparam logic [7:0] PORTA_IN_EN_MASK  = 8'hF9;
endpackage : timer_edge_osc_pkg

// >>> tb/timer_edge_osc_input_regs_bench.sv
`timescale 1ns/10ps
module timer_edge_osc_input_regs_bench;
  import timer_edge_osc_pkg::*;
  logic        clk = 0, srst = 1, ioWrEn = 0, ioRdEn = 0, mulStart = 0;
  logic        timerReqClear = 0, crystalClk = 0, fastRcClk = 0, slowRcClk = 0;
  logic [7:0]  ioAddr = 0, ioWrData = 0, mulOperand = 0, mulFactor = 0, portaPins = 0;
  logic [7:0]  ioRdData, portaInputEnable, rdv;
  logic        timerReqFlag, pinIrqFirst, pinIrqSecond, wakeEvent;
  logic        crystalEnable, bandgapPowerDown;
  logic [1:0]  crystalDrive;
  logic [15:0] timerCount, c0;
  int          errors = 0, compares = 0, nFirst = 0, nSecond = 0, nWake = 0;
  always #5 clk = ~clk;
  // crystal runs at one eighth of the system rate
  always #40 crystalClk = ~crystalClk;
  // rc sources toggle on falling edges only, so the synchronisers never race the sample edge
  always #20 fastRcClk = ~fastRcClk;
  always #100 slowRcClk = ~slowRcClk;
  always @(posedge clk) begin
    if (pinIrqFirst === 1'b1) nFirst++;
    if (pinIrqSecond === 1'b1) nSecond++;
    if (wakeEvent === 1'b1) nWake++;
  end
  timer_edge_osc_input_regs i_timer_edge_osc_input_regs (
    .clk(clk), .srst(srst), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .mulStart(mulStart),
    .mulOperand(mulOperand), .mulFactor(mulFactor), .fastRcClk(fastRcClk),
    .crystalClk(crystalClk), .slowRcClk(slowRcClk), .portaPins(portaPins),
    .timerReqClear(timerReqClear), .timerReqFlag(timerReqFlag), .timerCount(timerCount),
    .pinIrqFirst(pinIrqFirst), .pinIrqSecond(pinIrqSecond), .wakeEvent(wakeEvent),
    .portaInputEnable(portaInputEnable), .crystalEnable(crystalEnable),
    .crystalDrive(crystalDrive), .bandgapPowerDown(bandgapPowerDown));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1;
    @(negedge clk);
    ioWrEn = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioRdEn = 1;
    @(negedge clk);
    ioRdEn = 0;
    @(negedge clk);
    d = ioRdData;
  endtask : rd
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkRange(input string n, input int lo, input int hi, input logic [15:0] g);
    logic ok;
    ok = (g >= lo) && (g <= hi);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask : chkRange
  // pins pass a 2-stage synchroniser, so give each level time to land
  task automatic pin(input int i, input logic v);
    @(negedge clk);
    portaPins[i] = v;
    repeat (8) @(negedge clk);
  endtask : pin
  task automatic pulseBoth();
    nFirst = 0;
    nSecond = 0;
    nWake = 0;
    pin(4, 1);
    pin(4, 0);
    pin(0, 1);
    pin(0, 0);
  endtask : pulseBoth
  task automatic timerEvt(input logic [7:0] mode, input logic fall, input int b);
    int k;
    wr(ADDR_EDGE_SELECT, {3'h0, fall, 4'h0});
    wr(ADDR_TIMER_MODE, mode);
    // a new bit select may raise a stale event, so clear after it
    @(negedge clk);
    timerReqClear = 1;
    repeat (4) @(negedge clk);
    timerReqClear = 0;
    for (k = 0; k < 1100 && timerReqFlag !== 1'b1; k++) @(negedge clk);
    chk("evtbit", {15'h0, ~fall}, {15'h0, timerCount[b]});
    chkRange("evtlow", 0, 4, timerCount & ((16'h1 << b) - 16'h1));
    repeat (20) @(negedge clk);
    chk("sticky", 16'h1, {15'h0, timerReqFlag});
  endtask : timerEvt
  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge clk);
    srst = 0;
    chk("inen", 16'h00F9, {8'h0, portaInputEnable});
    chk("osc", 16'h0, {12'h0, crystalEnable, crystalDrive, bandgapPowerDown});
    rd(ADDR_TIMER_MODE, rdv);
    chk("mode", 16'h0, {8'h0, rdv});
    wr(ADDR_CRYSTAL_SET, 8'h41);
    chk("osc", 16'h5, {12'h0, crystalEnable, crystalDrive, bandgapPowerDown});
    wr(ADDR_CRYSTAL_SET, 8'hE0);
    chk("osc", 16'hE, {12'h0, crystalEnable, crystalDrive, bandgapPowerDown});
    rd(ADDR_CRYSTAL_SET, rdv);
    chk("rdwo", 16'h0, {8'h0, rdv});
    wr(ADDR_PORTA_IN_EN, 8'h19);
    chk("inen", 16'h0019, {8'h0, portaInputEnable});
    wr(8'h07, 8'h55);
    rd(8'h07, rdv);
    chk("unmap", 16'h0, {8'h0, rdv});
    mulOperand = 8'hFF;
    mulFactor = 8'hFF;
    mulStart = 1;
    @(negedge clk);
    mulStart = 0;
    wr(ADDR_PRODUCT_HIGH, 8'h12);
    rd(ADDR_PRODUCT_HIGH, rdv);
    chk("prod", 16'h00FE, {8'h0, rdv});
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_EDGE_SELECT, {4'h0, c[1:0], c[1:0]});
      pulseBoth();
      chk("first", (c == 0) ? 2 : (c == 3) ? 0 : 1, 16'(nFirst));
      chk("second", (c == 0) ? 2 : (c == 3) ? 0 : 1, 16'(nSecond));
    end
    wr(ADDR_EDGE_SELECT, 8'h00);
    wr(ADDR_PORTA_IN_EN, 8'hE8);
    pulseBoth();
    chk("gated", 16'h0, 16'(nFirst + nSecond + nWake));
    pin(3, 1);
    pin(3, 0);
    chk("wake", 16'h2, 16'(nWake));
    wr(ADDR_PORTA_IN_EN, 8'hF1);
    nWake = 0;
    pin(3, 1);
    pin(3, 0);
    chk("nowake", 16'h0, 16'(nWake));
    wr(ADDR_PORTA_IN_EN, 8'hF9);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TIMER_MODE, s ? 8'hE0 : 8'h60);
      repeat (8) @(negedge clk);
      c0 = timerCount;
      repeat (3) begin
        pin(s ? 0 : 4, 1);
        pin(s ? 0 : 4, 0);
      end
      chk("pinsrc", 16'h3, timerCount - c0);
    end
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TIMER_MODE, s ? 8'h40 : 8'h00);
      c0 = timerCount;
      repeat (30) @(negedge clk);
      chk("stopped", c0, timerCount);
    end
    wr(ADDR_PORTA_IN_EN, 8'h39);
    // fast rc, slow rc, then crystal, which the next step needs still selected
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_TIMER_MODE, {(s == 0) ? SRC_FAST_RC : (s == 1) ? SRC_SLOW_RC : SRC_CRYSTAL, 5'h00});
      c0 = timerCount;
      repeat (240) @(negedge clk);
      chkRange("oscsrc", (s == 0) ? 58 : (s == 1) ? 10 : 28,
               (s == 0) ? 62 : (s == 1) ? 14 : 32, timerCount - c0);
    end
    wr(ADDR_CRYSTAL_SET, 8'h00);
    repeat (10) @(negedge clk);
    c0 = timerCount;
    repeat (100) @(negedge clk);
    chk("xtaloff", c0, timerCount);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_TIMER_MODE, {3'h1, d[1:0], 3'h0});
      c0 = timerCount;
      repeat (256) @(negedge clk);
      chkRange("div", (256 >> (2 * d)) - 2, (256 >> (2 * d)) + 2, timerCount - c0);
    end
    timerEvt(8'h20, 1'b0, 8);
    timerEvt(8'h20, 1'b1, 8);
    timerEvt(8'h21, 1'b0, 9);
    timerReqClear = 1;
    @(negedge clk);
    timerReqClear = 0;
    wr(ADDR_TIMER_MODE, 8'h00);
    chk("clear", 16'h0, {15'h0, timerReqFlag});
    give_verdict();
  end
endmodule : timer_edge_osc_input_regs_bench
